// ### hdl/tcem_params.svh
// Constants for the terminal event message block
`ifndef TCEM_PARAMS_SVH
`define TCEM_PARAMS_SVH
`define TCEM_NCH         8
`define TCEM_MSG_BYTES   16
`define TCEM_QDEPTH      96
`define TCEM_OP_TXDONE   8'h01
`define TCEM_OP_INAVAIL  8'h02
`define TCEM_OP_DLDONE   8'h03
`define TCEM_OP_CDON     8'h04
`define TCEM_OP_CDOFF    8'h05
`define TCEM_OP_INIT     8'h06
`define TCEM_OP_BAUD     8'h07
`define TCEM_OP_SPECIAL  8'h08
`define TCEM_OP_DSRON    8'h09
`define TCEM_OP_DSROFF   8'h0a
`define TCEM_OP_RION     8'h0b
`define TCEM_OP_RIOFF    8'h0c
`define TCEM_OP_CLRRX    8'h15
`define TCEM_OFS_BIAS    16'h4000
`define TCEM_RX_LEN      16'h0400
`define TCEM_FLAG_SIGNAL 8'h02
`endif

// ### hdl/tcem_pkg.sv
// Types shared by both ends of the event message link
package tcem_pkg;
  typedef logic [7:0] tcem_byte_t;
  typedef logic [127:0] tcem_msg_t;
endpackage

// ### hdl/tcem_if.sv
// Link between controller and host: one 16-byte message each way
`timescale 1ns/1ps
interface tcem_if;
  import tcem_pkg::*;
  // Outbound (controller to host) message stream
  logic      out_valid;
  logic      out_ready;
  tcem_msg_t out_msg;
  // Inbound (host to controller) message stream
  logic      in_valid;
  logic      in_ready;
  tcem_msg_t in_msg;
  modport dev  (output out_valid, output out_msg, input out_ready,
                input in_valid, input in_msg, output in_ready);
  modport host (input out_valid, input out_msg, output out_ready,
                output in_valid, output in_msg, input in_ready);
endinterface

// ### hdl/tcem_host.sv
// Host end: receives messages, sends clear-receive-buffer releases
`timescale 1ns/1ps
`include "tcem_params.svh"
module tcem_host
  import tcem_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_b,
  tcem_if.host                 lnk,
  input  wire logic            rel_req,
  input  wire logic [2:0]      rel_chan,
  input  wire logic [15:0]     rel_count,
  output logic                 rel_busy,
  output logic                 msg_valid,
  output tcem_msg_t            msg_data,
  output logic [7:0]           active_lines,
  output logic                 dl_allowed,
  output logic [7:0]           baud_known,
  output logic [7:0]           tx_allowed,
  output logic [7:0]           cd_state
);
  tcem_msg_t   rx;
  logic [15:0] avail [`TCEM_NCH];
  logic [15:0] grant;
  assign rx = lnk.out_msg;
  // Host always accepts messages
  assign lnk.out_ready = 1'b1;

  // Received message tracking
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      msg_valid    <= 1'b0;
      msg_data     <= '0;
      active_lines <= 8'h00;
      dl_allowed   <= 1'b1;
      baud_known   <= 8'h00;
      tx_allowed   <= 8'hff;
      cd_state     <= 8'h00;
      for (int i = 0; i < `TCEM_NCH; i++)
        avail[i] <= 16'h0000;
    end
    else
    begin
      msg_valid <= lnk.out_valid;
      if (lnk.out_valid)
      begin
        msg_data <= rx;
        unique case (rx[7:0])
          `TCEM_OP_INIT: active_lines <= rx[23:16];
          `TCEM_OP_DLDONE: dl_allowed <= 1'b1;
          `TCEM_OP_BAUD: baud_known[rx[10:8]] <= 1'b1;
          `TCEM_OP_TXDONE: tx_allowed[rx[10:8]] <= 1'b1;
          `TCEM_OP_CDON: cd_state[rx[10:8]] <= 1'b1;
          `TCEM_OP_CDOFF: cd_state[rx[10:8]] <= 1'b0;
          `TCEM_OP_INAVAIL: avail[rx[10:8]] <= rx[31:16];
          default: ;
        endcase
      end
    end
  end

  assign grant = (rel_count > avail[rel_chan]) ? avail[rel_chan] : rel_count;

  // one inbound message at a time, held until taken
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lnk.in_valid <= 1'b0;
      lnk.in_msg   <= '0;
      rel_busy     <= 1'b0;
    end
    else if (lnk.in_valid)
    begin
      if (lnk.in_ready)
      begin
        lnk.in_valid <= 1'b0;
        rel_busy     <= 1'b0;
      end
    end
    else if (rel_req)
    begin
      lnk.in_msg   <= {96'h0, grant, 5'h00, rel_chan, `TCEM_OP_CLRRX};
      lnk.in_valid <= 1'b1;
      rel_busy     <= 1'b1;
    end
  end
endmodule

// ### hdl/tcem_dev.sv
// Controller end: builds event messages and handles buffer releases
`timescale 1ns/1ps
`include "tcem_params.svh"
// Summary of operation
// - host releases no more than reported
// - resend input-available if characters remain
// - transmit-complete carries channel and count
// - reported count is characters actually sent
// - host waits transmit-complete before next; the host's tx_allowed is never cleared, so it never waits
// - input-available carries count and offset
// - one input-available outstanding per channel
// - drop parity errors, framing error stores zero
// - keep parity bit, pad short formats ones
// - reported offset biased by 16384
// - host wraps circular receive buffer reads
// - download-complete gates next download; the host's dl_allowed is never cleared, so nothing is gated
// - carrier rise sends carrier-detect
// - assert-DTR with carrier sends carrier-detect
// - carrier fall sends carrier-loss
// - initialize reply carries active line map
// - autobaud-complete carries channel and rate
// - special character above high-water reported
// - DSR changes reported when enabled
// - RI changes reported both ways
// - sixteen bytes, reserved bytes zero
// - release without outstanding is ignored
// - host enqueues inbound messages in order
module tcem_dev
  import tcem_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_b,
  tcem_if.dev                  lnk,
  input  wire logic            tx_done,
  input  wire logic [2:0]      tx_chan,
  input  wire logic [7:0]      tx_sent,
  input  wire logic            rx_strobe,
  input  wire logic [2:0]      rx_chan,
  input  wire logic [7:0]      rx_char,
  input  wire logic [1:0]      rx_bits,
  input  wire logic            rx_parity_err,
  input  wire logic            rx_frame_err,
  input  wire logic [7:0]      special_mode,
  input  wire logic [7:0]      special_char,
  input  wire logic [15:0]     high_water,
  input  wire logic            dl_done,
  input  wire logic            init_done,
  input  wire logic [7:0]      init_lines,
  input  wire logic            baud_done,
  input  wire logic [2:0]      baud_chan,
  input  wire logic [15:0]     baud_rate,
  input  wire logic            dtr_assert,
  input  wire logic [2:0]      dtr_chan,
  input  wire logic [7:0]      dsr_report,
  input  wire logic [7:0]      cd_pin,
  input  wire logic [7:0]      dsr_pin,
  input  wire logic [7:0]      ri_pin,
  output logic                 busy,
  output logic                 rx_store,
  output logic [2:0]           rx_store_chan,
  output logic [7:0]           rx_store_data
);
  typedef enum {TCEM_IDLE, TCEM_SEND} tcem_state_t;
  tcem_state_t state;
  logic [7:0]  cd_m, cd_s, cd_q, dsr_m, dsr_s, dsr_q, ri_m, ri_s, ri_q;
  logic [15:0] cnt [`TCEM_NCH];
  logic [15:0] head [`TCEM_NCH];
  logic [7:0]  pick, pmask, src;
  logic [2:0]  pch;
  logic        strobe_hit, spec_hit, send_pick;
  logic [7:0]  outst;
  logic [7:0]  mdm_pend_cd_on, mdm_pend_cd_off, mdm_pend_dsr_on, mdm_pend_dsr_off;
  logic [7:0]  mdm_pend_ri_on, mdm_pend_ri_off, ia_pend;
  logic        rel_take;
  logic [2:0]  rel_ch;
  logic [15:0] rel_n;
  logic        good;
  logic [7:0]  stored;

  // Pack a two-argument message, reserved bytes zero
  function automatic tcem_msg_t mk(input tcem_byte_t op, input logic [2:0] ch,
                                   input logic [31:0] arg);
    mk = {80'h0, arg, 5'h00, ch, op};
  endfunction

  // Two-flop synchronisers for modem pins
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {cd_m, cd_s, cd_q}    <= '0;
      {dsr_m, dsr_s, dsr_q} <= '0;
      {ri_m, ri_s, ri_q}    <= '0;
    end
    else
    begin
      cd_m <= cd_pin;   cd_s <= cd_m;   cd_q <= cd_s;
      dsr_m <= dsr_pin; dsr_s <= dsr_m; dsr_q <= dsr_s;
      ri_m <= ri_pin;   ri_s <= ri_m;   ri_q <= ri_s;
    end
  end

  // parity errors dropped, framing errors become zero
  assign good = rx_strobe && !rx_parity_err;
  // a 6-bit char keeps parity in bit 6, so only bit 7 pads high
  // a 7-bit char keeps parity in bit 7 and passes as received
  always_comb
  begin
    stored = rx_char;
    if (rx_frame_err)
      stored = 8'h00;
    else if (rx_bits == 2'd0)
      stored = rx_char | 8'h80;
  end

  // Release decode; ignore if nothing outstanding
  assign rel_ch   = lnk.in_msg[10:8];
  assign rel_n    = lnk.in_msg[31:16];
  assign rel_take = lnk.in_valid && lnk.in_msg[7:0] == `TCEM_OP_CLRRX && outst[rel_ch];
  assign lnk.in_ready = 1'b1;

  // Strobes outrank queued flags; a flag clears only when its own message goes
  assign strobe_hit = tx_done || dl_done || init_done || baud_done;
  // the new character is not yet counted in the buffered total
  assign spec_hit   = good && special_mode[rx_chan] && stored == special_char
                      && cnt[rx_chan] >= high_water;
  assign send_pick  = state == TCEM_IDLE && !strobe_hit && !spec_hit;
  function automatic logic [7:0] taken(input tcem_byte_t code);
    taken = (send_pick && pick == code) ? pmask : 8'h00;
  endfunction

  // Receive buffer store and per-channel accounting
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_store      <= 1'b0;
      rx_store_chan <= 3'h0;
      rx_store_data <= 8'h00;
      for (int i = 0; i < `TCEM_NCH; i++)
      begin
        cnt[i]  <= 16'h0000;
        head[i] <= 16'h0000;
      end
    end
    else
    begin
      rx_store      <= good;
      rx_store_chan <= rx_chan;
      rx_store_data <= stored;
      for (int i = 0; i < `TCEM_NCH; i++)
        cnt[i] <= cnt[i] + ((good && rx_chan == 3'(i)) ? 16'h0001 : 16'h0000)
                  - ((rel_take && rel_ch == 3'(i)) ? rel_n : 16'h0000);
      if (rel_take)
        head[rel_ch] <= (head[rel_ch] + rel_n) % `TCEM_RX_LEN;
    end
  end

  // Pending event flags; set wins over clear
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      {mdm_pend_cd_on, mdm_pend_cd_off} <= '0;
      {mdm_pend_dsr_on, mdm_pend_dsr_off, mdm_pend_ri_on, mdm_pend_ri_off} <= '0;
    end
    else
    begin
      // carrier rise, DTR with carrier present
      mdm_pend_cd_on <= (mdm_pend_cd_on & ~taken(`TCEM_OP_CDON)) | (cd_s & ~cd_q)
                        | ((dtr_assert && cd_s[dtr_chan]) ? (8'h01 << dtr_chan) : 8'h00);
      mdm_pend_cd_off <= (mdm_pend_cd_off & ~taken(`TCEM_OP_CDOFF)) | (~cd_s & cd_q);
      mdm_pend_dsr_on <= (mdm_pend_dsr_on & ~taken(`TCEM_OP_DSRON))
                         | (dsr_s & ~dsr_q & dsr_report);
      mdm_pend_dsr_off <= (mdm_pend_dsr_off & ~taken(`TCEM_OP_DSROFF))
                          | (~dsr_s & dsr_q & dsr_report);
      mdm_pend_ri_on <= (mdm_pend_ri_on & ~taken(`TCEM_OP_RION)) | (ri_s & ~ri_q);
      mdm_pend_ri_off <= (mdm_pend_ri_off & ~taken(`TCEM_OP_RIOFF)) | (~ri_s & ri_q);
    end
  end

  // Arbitration: pick holds the winning class's opcode, lowest channel first
  always_comb
  begin
    pick = 8'h00;
    src  = 8'h00;
    if (|mdm_pend_cd_on)        begin pick = `TCEM_OP_CDON; src = mdm_pend_cd_on; end
    else if (|mdm_pend_cd_off)  begin pick = `TCEM_OP_CDOFF; src = mdm_pend_cd_off; end
    else if (|mdm_pend_dsr_on)  begin pick = `TCEM_OP_DSRON; src = mdm_pend_dsr_on; end
    else if (|mdm_pend_dsr_off) begin pick = `TCEM_OP_DSROFF; src = mdm_pend_dsr_off; end
    else if (|mdm_pend_ri_on)   begin pick = `TCEM_OP_RION; src = mdm_pend_ri_on; end
    else if (|mdm_pend_ri_off)  begin pick = `TCEM_OP_RIOFF; src = mdm_pend_ri_off; end
    else if (|ia_pend)          begin pick = `TCEM_OP_INAVAIL; src = ia_pend; end
    pch = 3'h0;
    for (int i = `TCEM_NCH - 1; i >= 0; i--)
      if (src[i])
        pch = 3'(i);
    pmask = 8'h01 << pch;
  end

  // input-available wanted when data waits and none outstanding
  always_comb
    for (int i = 0; i < `TCEM_NCH; i++)
      ia_pend[i] = !outst[i] && cnt[i] != 16'h0000;

  // Message sender: direct strobes take priority, then pending flags
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state         <= TCEM_IDLE;
      lnk.out_valid <= 1'b0;
      lnk.out_msg   <= '0;
      outst         <= 8'h00;
      busy          <= 1'b0;
    end
    else
    begin
      // release frees channel, new input-available follows if data remains
      if (rel_take)
        outst[rel_ch] <= 1'b0;
      unique case (state)
        TCEM_IDLE:
        begin
          busy <= 1'b0;
          if (tx_done)
            lnk.out_msg <= mk(`TCEM_OP_TXDONE, tx_chan, {24'h0, tx_sent});
          else if (dl_done)
            lnk.out_msg <= mk(`TCEM_OP_DLDONE, 3'h0, 32'h0);
          // active line bitmap in byte 2
          else if (init_done)
            lnk.out_msg <= mk(`TCEM_OP_INIT, 3'h0, {24'h0, init_lines});
          else if (baud_done)
            lnk.out_msg <= mk(`TCEM_OP_BAUD, baud_chan, {16'h0, baud_rate});
          else if (spec_hit)
            lnk.out_msg <= mk(`TCEM_OP_SPECIAL, rx_chan, {24'h0, stored});
          else if (pick == `TCEM_OP_INAVAIL)
            lnk.out_msg <= mk(`TCEM_OP_INAVAIL, pch,
                              {head[pch] + `TCEM_OFS_BIAS, cnt[pch]});
          else if (pick != 8'h00)
            lnk.out_msg <= mk(pick, pch, 32'h0);
          if (strobe_hit || spec_hit || pick != 8'h00)
          begin
            lnk.out_valid <= 1'b1;
            busy          <= 1'b1;
            state         <= TCEM_SEND;
            if (send_pick && pick == `TCEM_OP_INAVAIL)
              outst[pch] <= 1'b1;
          end
        end
        TCEM_SEND:
          // hold message while queue is full
          if (lnk.out_ready)
          begin
            lnk.out_valid <= 1'b0;
            state         <= TCEM_IDLE;
          end
      endcase
    end
  end
endmodule

// ### tb/tcem_checker.sv
// Link checker: message layout and release bookkeeping
`timescale 1ns/1ps
module tcem_checker
  import tcem_pkg::*;
(
  input wire logic      clk,
  input wire logic      rst_b,
  input wire logic      out_valid,
  input wire logic      out_ready,
  input wire tcem_msg_t out_msg,
  input wire logic      in_valid,
  input wire logic      in_ready,
  input wire tcem_msg_t in_msg
);
  logic [7:0] ia_open;
  logic [7:0] op;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Opcode on offer, zero when idle
  assign op = out_valid ? out_msg[7:0] : 8'h00;
  // Channels whose input-available waits for a release
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ia_open <= 8'h00;
    else
    begin
      if (in_valid && in_ready && in_msg[7:0] == 8'h15)
        ia_open[in_msg[10:8]] <= 1'b0;
      if (out_valid && out_ready && op == 8'h02)
        ia_open[out_msg[10:8]] <= 1'b1;
    end
  end
  sequence s_stall;
    out_valid && !out_ready;
  endsequence
  sequence s_ia_taken;
    out_valid && out_ready && op == 8'h02;
  endsequence
  a_stall_holds_msg: assert property (s_stall |=> out_valid && $stable(out_msg))
    else $error("message changed while stalled");
  a_opcode_in_range: assert property (out_valid |-> op inside {[8'h01:8'h0c]})
    else $error("unknown opcode");
  a_ia_single_open: assert property (s_ia_taken |-> !ia_open[out_msg[10:8]])
    else $error("second input-available before release");
  a_ia_layout: assert property (op == 8'h02 |-> out_msg[31:16] != 16'h0000
    && out_msg[127:48] == '0 && out_msg[15:11] == '0) else $error("bad input-available");
  a_ia_offset_bias: assert property (op == 8'h02 |-> out_msg[47:32] >= 16'h4000)
    else $error("offset below bias");
  a_txdone_layout: assert property (op == 8'h01 |-> out_msg[127:24] == '0)
    else $error("bad transmit-complete");
  a_dldone_layout: assert property (op == 8'h03 |-> out_msg[127:8] == '0)
    else $error("bad download-complete");
  a_init_layout: assert property (op == 8'h06 |-> out_msg[127:24] == '0 && out_msg[15:8] == '0)
    else $error("bad init reply");
  a_baud_layout: assert property (op == 8'h07 |-> out_msg[127:32] == '0)
    else $error("bad autobaud reply");
  a_special_layout: assert property (op == 8'h08 |-> out_msg[127:24] == '0)
    else $error("bad special report");
  a_modem_layout: assert property (op inside {8'h04, 8'h05, [8'h09:8'h0c]}
    |-> out_msg[127:11] == '0) else $error("bad modem report");
endmodule

// ### tb/testbench.sv
// Bench joining controller and host ends of the message link
`timescale 1ns/1ps
module testbench
  import tcem_pkg::*;
;
  typedef struct {logic [1:0] kind; logic [2:0] chan; logic [15:0] val; logic [7:0] op;} tcem_row_t;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        tx_done = 1'b0, dl_done = 1'b0, init_done = 1'b0, baud_done = 1'b0;
  logic        rx_strobe = 1'b0, rx_parity_err = 1'b0, rx_frame_err = 1'b0;
  logic        dtr_assert = 1'b0, rel_req = 1'b0;
  logic [2:0]  tx_chan = 3'h0, rx_chan = 3'h0, baud_chan = 3'h0, dtr_chan = 3'h0;
  logic [2:0]  rel_chan = 3'h0;
  logic [1:0]  rx_bits = 2'h2;
  logic [7:0]  tx_sent = 8'h00, rx_char = 8'h00, special_mode = 8'h00, special_char = 8'h00;
  logic [7:0]  init_lines = 8'h00, dsr_report = 8'h00, cd_pin = 8'h00;
  logic [7:0]  dsr_pin = 8'h00, ri_pin = 8'h00;
  logic [15:0] high_water = 16'hffff, baud_rate = 16'h0000, rel_count = 16'h0000, ofs;
  logic        busy, rx_store, rel_busy, msg_valid, dl_allowed;
  logic [2:0]  rx_store_chan;
  logic [7:0]  rx_store_data, active_lines, baud_known, tx_allowed, cd_state;
  tcem_msg_t   msg_data, e, got;
  tcem_msg_t   q[$];
  int          bad_count = 0, n_tests = 0;
  tcem_row_t   rows[8] = '{'{2'h0, 3'h0, 16'h0010, 8'h01}, '{2'h0, 3'h7, 16'h0000, 8'h01},
    '{2'h1, 3'h0, 16'h0000, 8'h03}, '{2'h2, 3'h0, 16'h00a5, 8'h06},
    '{2'h3, 3'h3, 16'h2580, 8'h07}, '{2'h3, 3'h7, 16'hffff, 8'h07},
    '{2'h0, 3'h3, 16'h00ff, 8'h01}, '{2'h2, 3'h0, 16'h003c, 8'h06}};
  tcem_if tcem_if_inst ();
  tcem_dev tcem_dev_inst (.clk(clk), .rst_b(rst_b), .lnk(tcem_if_inst.dev), .tx_done(tx_done),
    .tx_chan(tx_chan), .tx_sent(tx_sent), .rx_strobe(rx_strobe), .rx_chan(rx_chan),
    .rx_char(rx_char), .rx_bits(rx_bits), .rx_parity_err(rx_parity_err),
    .rx_frame_err(rx_frame_err), .special_mode(special_mode), .special_char(special_char),
    .high_water(high_water), .dl_done(dl_done), .init_done(init_done), .init_lines(init_lines),
    .baud_done(baud_done), .baud_chan(baud_chan), .baud_rate(baud_rate),
    .dtr_assert(dtr_assert), .dtr_chan(dtr_chan), .dsr_report(dsr_report), .cd_pin(cd_pin),
    .dsr_pin(dsr_pin), .ri_pin(ri_pin), .busy(busy), .rx_store(rx_store),
    .rx_store_chan(rx_store_chan), .rx_store_data(rx_store_data));
  tcem_host tcem_host_inst (.clk(clk), .rst_b(rst_b), .lnk(tcem_if_inst.host), .rel_req(rel_req),
    .rel_chan(rel_chan), .rel_count(rel_count), .rel_busy(rel_busy), .msg_valid(msg_valid),
    .msg_data(msg_data), .active_lines(active_lines), .dl_allowed(dl_allowed),
    .baud_known(baud_known), .tx_allowed(tx_allowed), .cd_state(cd_state));
  tcem_checker tcem_checker_inst (.clk(clk), .rst_b(rst_b), .out_valid(tcem_if_inst.out_valid),
    .out_ready(tcem_if_inst.out_ready), .out_msg(tcem_if_inst.out_msg),
    .in_valid(tcem_if_inst.in_valid), .in_ready(tcem_if_inst.in_ready),
    .in_msg(tcem_if_inst.in_msg));
  // Free-running 250 MHz clock
  always #2 clk = ~clk;
  // Collect every message the host end delivers
  always @(negedge clk)
    if (msg_valid === 1'b1)
      q.push_back(msg_data);
  task automatic chk(input string nm, input logic [127:0] x, input logic [127:0] y);
    n_tests++;
    if (y !== x)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, x, y);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Strobes are only taken while idle, so wait for that first
  task automatic wait_idle();
    do @(negedge clk); while (busy === 1'b1);
  endtask
  // Order does not matter: search the collected messages
  task automatic expect_msg(input string nm, input tcem_msg_t x, input tcem_msg_t m);
    int k;
    k = -1;
    for (int n = 0; n < 300 && k < 0; n++)
    begin
      foreach (q[i])
        if (k < 0 && (q[i] & m) === (x & m))
          k = i;
      if (k < 0)
        @(negedge clk);
    end
    got = (k < 0) ? '0 : q[k];
    if (k >= 0)
      q.delete(k);
    chk(nm, x & m, got & m);
  endtask
  task automatic send_ev(input tcem_row_t r);
    wait_idle();
    {tx_chan, baud_chan, tx_sent, init_lines, baud_rate} = {r.chan, r.chan, r.val[7:0], r.val[7:0], r.val};
    {tx_done, dl_done, init_done, baud_done} = 4'h8 >> r.kind;
    for (int n = 0; n < 50 && busy !== 1'b1; n++)
      @(negedge clk);
    {tx_done, dl_done, init_done, baud_done} = 4'h0;
  endtask
  task automatic modem(input logic [7:0] o, input logic [2:0] c);
    expect_msg("modem message", {117'h0, c, o}, '1);
  endtask
  task automatic rx_one(input logic [7:0] c, input logic [1:0] b, input logic [1:0] er,
                        input logic [8:0] x);
    wait_idle();
    {rx_strobe, rx_chan, rx_char, rx_bits, rx_parity_err, rx_frame_err} = {4'ha, c, b, er};
    @(negedge clk);
    rx_strobe = 1'b0;
    chk("stored char", x, x[8] ? {rx_store, rx_store_data} : {rx_store, x[7:0]});
  endtask
  task automatic release_buf(input logic [2:0] c, input logic [15:0] n);
    do @(negedge clk); while (rel_busy === 1'b1);
    {rel_req, rel_chan, rel_count} = {1'b1, c, n};
    @(negedge clk);
    rel_req = 1'b0;
  endtask
  task automatic reset_check();
    chk("reset state", {6'h02, 8'hff, 24'h0}, {busy, rx_store, rel_busy, msg_valid, dl_allowed,
      tcem_if_inst.out_valid, tx_allowed, active_lines, baud_known, cd_state});
  endtask
  // Hang guard, well beyond the expected run
  initial
  begin
    repeat (30000) @(posedge clk);
    bad_count++;
    stop_test();
  end
  initial
  begin
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    reset_check();
    foreach (rows[i])
    begin
      send_ev(rows[i]);
      e = {96'h0, rows[i].val[15:8], rows[i].val[7:0], 8'h00, rows[i].op};
      if (rows[i].kind != 2'h3) e[31:24] = 8'h00;
      if (rows[i].kind == 2'h1) e[23:16] = 8'h00;
      if (rows[i].kind == 2'h0 || rows[i].kind == 2'h3) e[10:8] = rows[i].chan;
      expect_msg("event message", e, '1);
    end
    repeat (2) @(negedge clk);
    chk("host status", {8'h3c, 8'h88, 1'b1}, {active_lines, baud_known, dl_allowed});
    cd_pin = 8'h02;
    modem(8'h04, 3'h1);
    repeat (2) @(negedge clk);
    chk("carrier state", 8'h02, cd_state);
    wait_idle();
    {dtr_assert, dtr_chan} = 4'h9;
    @(negedge clk);
    dtr_assert = 1'b0;
    modem(8'h04, 3'h1);
    cd_pin = 8'h00;
    modem(8'h05, 3'h1);
    {dsr_report, dsr_pin} = {8'h08, 8'h18};
    modem(8'h09, 3'h3);
    dsr_pin = 8'h00;
    modem(8'h0a, 3'h3);
    ri_pin = 8'h20;
    modem(8'h0b, 3'h5);
    ri_pin = 8'h00;
    modem(8'h0c, 3'h5);
    rx_one(8'h41, 2'h2, 2'h0, 9'h141);
    expect_msg("input available", 128'h010202, ~(128'hffff << 32));
    ofs = got[47:32];
    chk("offset bias", 1'b1, ofs >= 16'h4000);
    rx_one(8'h35, 2'h0, 2'h0, 9'h1b5);
    rx_one(8'h62, 2'h2, 2'h2, 9'h062);
    rx_one(8'h7f, 2'h1, 2'h1, 9'h100);
    release_buf(3'h2, 16'h0001);
    expect_msg("remaining input", {80'h0, ofs + 16'h0001, 32'h00020202}, '1);
    release_buf(3'h2, 16'h0002);
    release_buf(3'h6, 16'h0000);
    {special_mode, special_char, high_water} = {16'h042a, 16'h0000};
    rx_one(8'h2a, 2'h2, 2'h0, 9'h12a);
    expect_msg("special char", 128'h2a0208, '1);
    expect_msg("new input", {80'h0, ofs + 16'h0003, 32'h00010202}, '1);
    release_buf(3'h2, 16'h0001);
    repeat (100) @(negedge clk);
    chk("spare messages", 128'h0, 128'(q.size()));
    rst_b = 1'b0;
    repeat (8) @(negedge clk);
    reset_check();
    // Second release: nothing may stir in the first two cycles
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    reset_check();
    stop_test();
  end
endmodule
